// *** pkg/uart_hs_map.vh ***
// constants for the processor-side handshake of the serial receiver/transmitter
`ifndef UART_HS_MAP_VH
`define UART_HS_MAP_VH
// register select codes (mode 1)
`define SEL_DATA           1'b0
`define SEL_CTRL_STATUS    1'b1
// status byte field positions
`define ST_DA_BIT          0
`define ST_OE_BIT          1
`define ST_PE_BIT          2
`define ST_FE_BIT          3
`define ST_TX_HOLDING_EMPTY_BIT        7
// control word reset value and field positions
`define CTRL_RESET         8'h00
`define CTRL_PAR_INH_BIT   0
`define CTRL_EVEN_BIT      1
`define CTRL_STOP2_BIT     2
`define CTRL_WLS_LSB       3
// synchroniser reset levels, one bit per pin at its idle level
`define SYNC_IDLE_LVL      10'h24F
// serial clock divider: receive/transmit clock is sixteen times the bit rate
`define BIT_DIV_CNT        16'h0036
`define OVERSAMPLE         4'hF
`define HALF_OVERSAMPLE    4'h7
// transmit FIFO shape
`define TXF_WIDTH          8
`define TXF_DEPTH          8
`define TXF_AW             3
`endif

// *** hdl/tx_fifo.v ***
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             reset,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_q;
    reg [AW:0]      rd_q;
    wire            full;
    wire            empty;

    // extra pointer bit separates full from empty
    assign empty     = (wr_q == rd_q);
    assign full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_q[AW-1:0]];

    // storage write
    always @(posedge clk_sys)
    begin
        if (in_valid && !full)
            mem[wr_q[AW-1:0]] <= in_data;
    end

    // pointers
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (in_valid && !full)
                wr_q <= wr_q + 1'b1;
            if (out_ready && !empty)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// *** hdl/uart_cpu_bus_handshake.v ***
// processor-side handshake, holding registers and serial engines of the uart
`timescale 1ns/1ps
`include "uart_hs_map.vh"
module uart_cpu_bus_handshake (
    // clock and reset
    input  wire       clk_sys,
    input  wire       reset,
    // mode and processor bus pins
    input  wire       mode_bus,
    input  wire       bus_timing_pulse,
    input  wire       chip_select_first,
    input  wire       chip_select_second_n,
    input  wire       chip_select_third,
    input  wire       read_not_write,
    input  wire       register_select,
    input  wire [7:0] bus_data_in,
    output reg  [7:0] bus_data_out,
    output wire       bus_data_oe_n,
    // standalone pins
    input  wire       control_register_load_n,
    input  wire [7:0] control_word_in,
    input  wire       tx_holding_load_n,
    input  wire       data_available_reset_n,
    input  wire       rx_register_disable,
    input  wire       status_flag_disable,
    output wire [7:0] rx_data_out,
    output wire       rx_data_oe_n,
    // status pins
    output wire       data_available_flag,
    output wire       error_out,
    output wire       parity_error,
    output wire       framing_error,
    output wire       tx_holding_empty,
    // serial line
    input  wire       serial_input_data,
    output wire       serial_output_data
);
    // synchronisers: ten pins pass through them; data, register select and the disables are used directly
    localparam NS = 10;
    // idle levels at reset, so no false edge follows reset
    localparam [NS-1:0] SYNC_IDLE = `SYNC_IDLE_LVL;
    reg  [NS-1:0] s1_q;
    reg  [NS-1:0] s2_q;
    reg  [NS-1:0] s3_q;
    wire [NS-1:0] pins_raw;
    assign pins_raw = {serial_input_data, bus_timing_pulse, chip_select_first,
                       chip_select_second_n, chip_select_third, read_not_write,
                       control_register_load_n, tx_holding_load_n,
                       data_available_reset_n, mode_bus};
    genvar g;
    generate
        for (g = 0; g < NS; g = g + 1)
        begin : g_sync
            always @(posedge clk_sys)
            begin
                if (reset)
                begin
                    s1_q[g] <= SYNC_IDLE[g];
                    s2_q[g] <= SYNC_IDLE[g];
                    s3_q[g] <= SYNC_IDLE[g];
                end
                else
                begin
                    s1_q[g] <= pins_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                end
            end
        end
    endgenerate

    wire rxd_s   = s2_q[9];
    wire tpb_s   = s2_q[8];
    wire tpb_fall = s3_q[8] & ~s2_q[8];
    wire cs1_s   = s2_q[7];
    wire cs2n_s  = s2_q[6];
    wire cs3_s   = s2_q[5];
    wire rnw_s   = s2_q[4];
    wire crl_rise = ~s3_q[3] & s2_q[3];
    wire thrl_rise = ~s3_q[2] & s2_q[2];
    wire dar_fall = s3_q[1] & ~s2_q[1];
    wire bus_mode = s2_q[0];

    // decode of the processor bus cycles
    wire sel_ok   = cs1_s & ~cs2n_s & cs3_s;
    wire wr_cycle = bus_mode & sel_ok & ~rnw_s & tpb_s;
    reg  wr_seen_q;
    reg  rd_seen_q;
    reg  register_select_q;
    wire rd_cycle = bus_mode & sel_ok & rnw_s;
    wire wr_end   = wr_seen_q & tpb_fall;
    wire rd_end   = rd_cycle & tpb_fall & (register_select_q == `SEL_DATA);

    // remember select state while the pulse is high
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_seen_q <= 1'b0;
            rd_seen_q <= 1'b0;
            register_select_q    <= `SEL_DATA;
        end
        else
        begin
            wr_seen_q <= wr_cycle;
            rd_seen_q <= rd_cycle;
            if (tpb_s)
                register_select_q <= register_select;
        end
    end

    // control word: standalone load pulse or bus write to control address
    reg [7:0] ctrl_q;
    reg [7:0] wr_data_q;
    always @(posedge clk_sys)
    begin
        if (reset)
            ctrl_q <= `CTRL_RESET;
        else if (!bus_mode && crl_rise)
            ctrl_q <= control_word_in;
        else if (wr_end && register_select_q == `SEL_CTRL_STATUS)
            ctrl_q <= wr_data_q;
    end

    // bus data sampled while write overlap holds, used at trailing edge
    always @(posedge clk_sys)
    begin
        if (reset)
            wr_data_q <= 8'h00;
        else if (wr_cycle)
            wr_data_q <= bus_data_in;
    end

    // slow serial clock enable (oversampling tick)
    reg [15:0] div_q;
    wire       tick = (div_q == 16'h0000);
    always @(posedge clk_sys)
    begin
        if (reset || tick)
            div_q <= `BIT_DIV_CNT;
        else
            div_q <= div_q - 16'h0001;
    end

    wire [3:0] wlen = 4'h5 + {2'b00, ctrl_q[`CTRL_WLS_LSB+1:`CTRL_WLS_LSB]};

    // holding register path through the FIFO; back-pressure refuses writes
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire       load_hold = bus_mode ? (wr_end && register_select_q == `SEL_DATA) : thrl_rise;
    wire       tx_take;
    tx_fifo #(
        .WIDTH (`TXF_WIDTH),
        .DEPTH (`TXF_DEPTH),
        .AW    (`TXF_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (load_hold),
        .in_ready  (fifo_in_ready),
        .in_data   (bus_mode ? wr_data_q : bus_data_in),
        .out_valid (fifo_out_valid),
        .out_ready (tx_take),
        .out_data  (fifo_out_data)
    );
    assign tx_holding_empty = ~fifo_out_valid;

    // transmitter: shift register loads only when idle, on a tick
    reg [11:0] tsr_q;
    reg [3:0]  tbits_q;
    reg [3:0]  tos_q;
    reg        txd_q;
    wire       tsr_empty = (tbits_q == 4'h0);
    wire       tpar = ^fifo_out_data ^ ~ctrl_q[`CTRL_EVEN_BIT];
    assign tx_take = tsr_empty & tick & fifo_out_valid;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            tsr_q   <= 12'hFFF;
            tbits_q <= 4'h0;
            tos_q   <= 4'h0;
            txd_q   <= 1'b1;
        end
        else if (tx_take)
        begin
            // frame: start, data lsb first, parity, stop(s)
            tsr_q   <= {2'b11, tpar, fifo_out_data, 1'b0} >> 0;
            tbits_q <= wlen + 4'h2 + {3'b000, ~ctrl_q[`CTRL_PAR_INH_BIT]}
                       + {3'b000, ctrl_q[`CTRL_STOP2_BIT]};
            tos_q   <= `OVERSAMPLE;
            txd_q   <= 1'b1;
        end
        else if (tick && !tsr_empty)
        begin
            tos_q <= tos_q - 4'h1;
            if (tos_q == `OVERSAMPLE)
            begin
                // start bit appears after the load tick
                txd_q <= tsr_q[0];
                tsr_q <= (tbits_q == wlen + 4'h2) && ctrl_q[`CTRL_PAR_INH_BIT] ?
                         {2'b11, tsr_q[11:10], tsr_q[8:1]} : {1'b1, tsr_q[11:1]};
            end
            if (tos_q == 4'h0)
                tbits_q <= tbits_q - 4'h1;
        end
    end
    assign serial_output_data = status_flag_disable & ~bus_mode ? 1'b1 : txd_q;

    // receiver: start bit sampled through synchroniser, centre sampling
    reg [9:0] rsr_q;
    reg [3:0] rbits_q;
    reg [3:0] ros_q;
    reg       rbusy_q;
    reg       rdone_q;
    wire [3:0] rtotal = wlen + 4'h1 + {3'b000, ~ctrl_q[`CTRL_PAR_INH_BIT]};
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rsr_q   <= 10'h000;
            rbits_q <= 4'h0;
            ros_q   <= 4'h0;
            rbusy_q <= 1'b0;
            rdone_q <= 1'b0;
        end
        else
        begin
            rdone_q <= 1'b0;
            if (tick)
            begin
                if (!rbusy_q && !rxd_s)
                begin
                    // a late start edge simply waits for the next tick
                    rbusy_q <= 1'b1;
                    ros_q   <= `HALF_OVERSAMPLE;
                    rbits_q <= 4'h0;
                end
                else if (rbusy_q)
                begin
                    ros_q <= ros_q - 4'h1;
                    if (ros_q == 4'h0)
                    begin
                        ros_q <= `OVERSAMPLE;
                        if (rbits_q == 4'h0 && rxd_s)
                            rbusy_q <= 1'b0;               // false start
                        else if (rbits_q == rtotal)
                        begin
                            rbusy_q <= 1'b0;
                            rdone_q <= 1'b1;
                            rsr_q   <= {rxd_s, rsr_q[9:1]};
                        end
                        else
                        begin
                            rbits_q <= rbits_q + 4'h1;
                            if (rbits_q != 4'h0)
                                rsr_q <= {rxd_s, rsr_q[9:1]};
                        end
                    end
                end
            end
        end
    end

    // receive holding register and flags
    reg [7:0] rhr_q;
    reg       da_q;
    reg       oe_q;
    reg       pe_q;
    reg       fe_q;
    wire [9:0] raligned = rsr_q >> (4'hA - rtotal);
    wire [7:0] rword = raligned[7:0] & ~(8'hFF << wlen);
    wire       rpar = raligned[wlen];
    wire       rstop = rsr_q[9];
    wire       da_clear = bus_mode ? rd_end : dar_fall;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rhr_q <= 8'h00;
            da_q  <= 1'b0;
            oe_q  <= 1'b0;
            pe_q  <= 1'b0;
            fe_q  <= 1'b0;
        end
        else if (rdone_q)
        begin
            // completion wins over a read in the same cycle
            rhr_q <= rword;
            da_q  <= 1'b1;
            oe_q  <= da_q & ~da_clear;
            pe_q  <= ~ctrl_q[`CTRL_PAR_INH_BIT] &
                     (^rword ^ rpar ^ ~ctrl_q[`CTRL_EVEN_BIT]);
            fe_q  <= ~rstop;
        end
        else if (da_clear)
            da_q <= 1'b0;
    end

    // bus read data: data register or status byte
    wire [7:0] status_byte = {~fifo_out_valid, 3'b000, fe_q, pe_q, oe_q, da_q};
    always @(posedge clk_sys)
    begin
        if (reset)
            bus_data_out <= 8'h00;
        else
            bus_data_out <= (register_select == `SEL_DATA) ? rhr_q : status_byte;
    end
    assign bus_data_oe_n = ~rd_seen_q;

    // standalone receive outputs
    assign rx_data_out  = rhr_q;
    assign rx_data_oe_n = bus_mode | rx_register_disable;

    // status pins; overrun and parity share one pin in bus mode
    assign data_available_flag = da_q;
    assign error_out     = bus_mode ? (oe_q | pe_q) : oe_q;
    assign parity_error  = pe_q;
    assign framing_error = fe_q;
endmodule

// *** test/uart_hs_monitor.sv ***
// concurrent checks on the pins of the uart processor handshake
`timescale 1ns/1ps
module uart_hs_monitor (
    // clock, reset, mode
    input wire clk_sys,
    input wire reset,
    input wire mode_bus,
    // processor bus pins
    input wire bus_timing_pulse,
    input wire chip_select_first,
    input wire chip_select_second_n,
    input wire chip_select_third,
    input wire read_not_write,
    input wire register_select,
    input wire bus_data_oe_n,
    // standalone and status pins
    input wire rx_register_disable,
    input wire rx_data_oe_n,
    input wire data_available_flag,
    input wire error_out,
    input wire parity_error,
    input wire tx_holding_empty,
    input wire serial_output_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire sel_ok = mode_bus && chip_select_first && !chip_select_second_n && chip_select_third;
    // idle run length: start timing only holds when the shifter is empty
    reg [13:0] idle_q;
    always @(posedge clk_sys)
    begin
        if (reset || !serial_output_data)
            idle_q <= 14'h0000;
        else if (idle_q != 14'h3FFF)
            idle_q <= idle_q + 14'h0001;
    end
    // pulse with data-register write overlap, then its falling edge
    sequence s_write;
        (sel_ok && !read_not_write && !register_select && bus_timing_pulse)[*3]
        ##1 (sel_ok && !bus_timing_pulse);
    endsequence
    sequence s_read;
        (sel_ok && read_not_write && !register_select && bus_timing_pulse)[*3]
        ##1 (sel_ok && !bus_timing_pulse);
    endsequence
    chk_write_holds: assert property (s_write |-> ##[1:6] !tx_holding_empty)
        else $error("holding register did not take the write");
    chk_start_bit: assert property ($fell(tx_holding_empty) && idle_q[13:12] == 2'h3 |-> ##[1:200] !serial_output_data)
        else $error("start bit late after holding load");
    chk_read_drive: assert property ((sel_ok && read_not_write)[*4] |-> !bus_data_oe_n)
        else $error("read overlap not driving the bus");
    chk_bus_float: assert property ((!chip_select_first)[*4] |-> bus_data_oe_n)
        else $error("bus driven without read overlap");
    chk_da_clear: assert property (s_read |-> ##[1:6] !data_available_flag)
        else $error("data read left data available set");
    chk_da_stays: assert property ($rose(data_available_flag) |=> data_available_flag[*3])
        else $error("data available dropped by itself");
    chk_err_shared: assert property ((mode_bus && parity_error)[*4] |-> error_out)
        else $error("parity error missing on shared pin");
    chk_rx_float: assert property (rx_register_disable[*4] |-> rx_data_oe_n)
        else $error("receive outputs driven while disabled");
    chk_rx_drive: assert property ((!mode_bus && !rx_register_disable)[*4] |-> !rx_data_oe_n)
        else $error("receive outputs floating while enabled");
endmodule

bind uart_cpu_bus_handshake uart_hs_monitor u_mon (.*);

// *** test/serial_peer.sv ***
// serial line partner: sends frames in, captures bytes sent out
`timescale 1ns/1ps
module serial_peer #(
    parameter BIT = 880
) (
    // clock and line
    input  wire clk_sys,
    input  wire tx_line,
    output reg  rx_line
);
    reg [7:0] got_q;
    reg [10:0] frame;
    integer   i;
    integer   j;
    // start, nine bits lsb first, stop; line rests at mark level
    task send(input [8:0] bits);
        begin
            frame = {1'b1, bits, 1'b0};
            for (i = 0; i < 11; i = i + 1)
            begin
                rx_line <= frame[i];
                repeat (BIT) @(posedge clk_sys);
            end
        end
    endtask
    // sample mid-bit; parity and stop are not kept
    initial
    begin
        rx_line = 1'b1;
        got_q = 8'h00;
        forever
        begin
            @(negedge tx_line);
            repeat (BIT + BIT / 2) @(posedge clk_sys);
            for (j = 0; j < 8; j = j + 1)
            begin
                got_q[j] = tx_line;
                repeat (BIT) @(posedge clk_sys);
            end
        end
    end
endmodule

// *** test/testbench.sv ***
// self-checking bench for the uart processor-side handshake
`timescale 1ns/1ps
module testbench;
    localparam BIT = 880; // 55 cycles a tick, 16 ticks a bit
    reg        clk_sys, reset, mode_bus, bus_timing_pulse, chip_select_first;
    reg        chip_select_second_n, chip_select_third, read_not_write;
    reg        register_select, rx_register_disable, control_register_load_n;
    reg        data_available_reset_n;
    reg  [7:0] bus_data_in, rd_q, control_word_in;
    wire [7:0] bus_data_out, rx_data_out;
    wire       bus_data_oe_n, rx_data_oe_n, data_available_flag, error_out;
    wire       parity_error, tx_holding_empty, serial_input_data, serial_output_data;
    wire       framing_error;
    integer    fail_count, checks, n;
    // standalone holding load and flag disable stay idle
    uart_cpu_bus_handshake u_dut (
        .clk_sys, .reset, .mode_bus, .bus_timing_pulse, .chip_select_first,
        .chip_select_second_n, .chip_select_third, .read_not_write, .register_select,
        .bus_data_in, .bus_data_out, .bus_data_oe_n, .control_register_load_n,
        .control_word_in, .tx_holding_load_n(1'b1), .data_available_reset_n,
        .rx_register_disable, .status_flag_disable(1'b0), .rx_data_out, .rx_data_oe_n,
        .data_available_flag, .error_out, .parity_error, .framing_error,
        .tx_holding_empty, .serial_input_data, .serial_output_data);
    serial_peer #(.BIT(BIT)) u_peer (
        .clk_sys, .tx_line(serial_output_data), .rx_line(serial_input_data));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk_sys);
            #1;
        end
    endtask
    task check(input string what, input [7:0] exp, input [7:0] got);
        begin
            checks = checks + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d fail_count %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // bounded wait for data available or for a start bit
    task wait_until(input bit on_da);
        begin
            n = 0;
            while ((on_da ? data_available_flag : !serial_output_data) !== 1'b1 && n < 2000)
            begin
                tick(1);
                n = n + 1;
            end
            if (n == 2000)
            begin
                check("wait", 8'h01, 8'h00);
                end_of_test;
            end
        end
    endtask
    // one processor cycle; selects held well around the pulse
    task bus_cycle(input rnw, input sel, input [7:0] d);
        begin
            {chip_select_first, chip_select_second_n, chip_select_third} = 3'h5;
            read_not_write = rnw;
            register_select = sel;
            bus_data_in = d;
            tick(3);
            bus_timing_pulse = 1'b1;
            tick(4);
            rd_q = bus_data_out;
            bus_timing_pulse = 1'b0;
            tick(4);
            {chip_select_first, chip_select_second_n} = 2'h1;
            tick(3);
        end
    endtask
    // 8 bits, even parity; long idle, then one byte out
    task test_tx;
        begin
            bus_cycle(1'b0, 1'b1, 8'h1A);
            tick(12400);
            bus_cycle(1'b0, 1'b0, 8'hC3);
            wait_until(1'b0);
            tick(10 * BIT);
            check("tx byte", 8'hC3, u_peer.got_q);
            check("holding empty", 8'h01, {7'h00, tx_holding_empty});
        end
    endtask
    task test_rx;
        begin
            u_peer.send({1'b0, 8'hA5});
            wait_until(1'b1);
            bus_cycle(1'b1, 1'b0, 8'h00);
            check("rx byte", 8'hA5, rd_q);
            check("framing", 8'h00, {7'h00, framing_error});
            check("da after read", 8'h00, {7'h00, data_available_flag});
        end
    endtask
    // bad parity, then an unread word overruns
    task test_errors;
        begin
            u_peer.send({1'b0, 8'h01});
            wait_until(1'b1);
            tick(4);
            check("error pin parity", 8'h01, {7'h00, error_out});
            u_peer.send({1'b0, 8'h3C});
            tick(4);
            check("parity cleared", 8'h00, {7'h00, parity_error});
            check("error pin overrun", 8'h01, {7'h00, error_out});
            bus_cycle(1'b1, 1'b1, 8'h00);
            check("status overrun", 8'h03, rd_q & 8'h03);
            bus_cycle(1'b1, 1'b0, 8'h00);
            check("overrun byte", 8'h3C, rd_q);
        end
    endtask
    task test_standalone;
        begin
            mode_bus = 1'b0;
            rx_register_disable = 1'b1;
            tick(6);
            check("rx floated", 8'h01, {7'h00, rx_data_oe_n});
            rx_register_disable = 1'b0;
            tick(6);
            check("rx driven", 8'h00, {7'h00, rx_data_oe_n});
            check("rx data", 8'h3C, rx_data_out);
            // odd parity through the standalone latch; old even setting would flag it
            control_word_in = 8'h18;
            control_register_load_n = 1'b0;
            tick(4);
            control_register_load_n = 1'b1;
            tick(4);
            u_peer.send({1'b0, 8'h01});
            tick(4);
            check("odd parity ok", 8'h00, {7'h00, parity_error});
            check("rx standalone", 8'h01, rx_data_out);
            check("da standalone", 8'h01, {7'h00, data_available_flag});
            check("no overrun", 8'h00, {7'h00, error_out});
            data_available_reset_n = 1'b0;
            tick(4);
            data_available_reset_n = 1'b1;
            check("da reset", 8'h00, {7'h00, data_available_flag});
            tick(4);
        end
    endtask
    initial
    begin
        fail_count = 0;
        checks = 0;
        {reset, mode_bus, chip_select_second_n} = 3'h7;
        {bus_timing_pulse, chip_select_first, chip_select_third} = 3'h0;
        {read_not_write, register_select, rx_register_disable} = 3'h0;
        bus_data_in = 8'h00;
        {control_register_load_n, data_available_reset_n} = 2'h3;
        control_word_in = 8'h00;
        tick(6);
        reset = 1'b0;
        tick(4);
        test_tx;
        test_rx;
        test_errors;
        test_standalone;
        end_of_test;
    end
endmodule
